/* hdl/serial_port_defines.vh */
// register offsets, field positions, reset values and timing for the serial port
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
// register indices as printed; byte address is four times the index
`define IDX_SLAVE_ADDR_VALUE 8'hA9
`define IDX_SLAVE_ADDR_MASK 8'hB9
`define IDX_SERIAL_CONTROL 8'h98
`define IDX_SERIAL_BUFFER 8'h99
`define IDX_POWER_CONTROL 8'h87
`define IDX_BAUD_RELOAD 8'hC0
// control register fields
`define CTL_RECV_DONE 0
`define CTL_XMIT_DONE 1
`define CTL_RX_NINTH 2
`define CTL_TX_NINTH 3
`define CTL_RX_ENABLE 4
`define CTL_MULTIPROC 5
`define CTL_MODE_LO 6
`define CTL_MODE_HI 7
// power control fields
`define PWR_FE_SELECT 6
`define PWR_BAUD_DOUBLER 7
// reset values
`define RST_BYTE 8'h00
`define RST_RELOAD 16'h0000
// modes
`define MODE_SYNC 2'b00
`define MODE_ASYNC10 2'b01
`define MODE_ASYNC11_OSC 2'b10
`define MODE_ASYNC11_TMR 2'b11
// sixteen-state bit counter and vote points
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define LAST_SLICE 4'hF
`define BITS_ASYNC10 4'hA
`define BITS_ASYNC11 4'hB
`endif

/* hdl/baud_tick.v */
// oversample tick generator: oscillator division or programmable reload
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"
module baud_tick (
    input wire clk_sys,
    input wire nrst,
    input wire [1:0] mode,
    input wire doubler,
    input wire [15:0] reload,
    output reg tick_ff
);
    reg [15:0] cnt_ff;
    reg [15:0] nxt_cnt;
    reg [15:0] limit;

    // mode 2: fixed 2 or 4 clocks per slice (32/64 osc per bit);
    // modes 1 and 3 use the programmable reload as the timer source
    always @* begin
        if (mode == `MODE_ASYNC11_OSC)
            limit = doubler ? 16'h0001 : 16'h0003;
        else
            limit = doubler ? reload : {reload[14:0], 1'b1};
        nxt_cnt = (cnt_ff >= limit) ? 16'h0000 : cnt_ff + 16'h0001;
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= (cnt_ff >= limit);
        end
    end
endmodule
`default_nettype wire

/* hdl/addr_match.v */
// multiprocessor given/broadcast address comparison
`timescale 1ns/1ps
`default_nettype none
module addr_match (
    input wire [7:0] rx_byte,
    input wire [7:0] addr_value,
    input wire [7:0] addr_mask,
    output wire hit
);
    wire [7:0] bcast;
    wire given_hit;
    wire bcast_hit;

    // only mask ones take part in the given compare
    assign given_hit = ((rx_byte ^ addr_value) & addr_mask) == 8'h00;
    // broadcast: zeros of value|mask are don't-care
    assign bcast = addr_value | addr_mask;
    assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
    // both registers zero makes every byte a hit
    assign hit = given_hit | bcast_hit;
endmodule
`default_nettype wire

/* hdl/serial_port.v */
// enhanced async serial port with frame error and address recognition
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"
module serial_port (
    input wire clk_sys,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rxd,
    output reg txd_ff
);
    // receive and transmit state codes
    localparam RX_IDLE = 2'd0;
    localparam RX_BITS = 2'd1;
    localparam TX_IDLE = 2'd0;
    localparam TX_WAIT = 2'd1;
    localparam TX_SHIFT = 2'd2;

    // registers
    reg mode_hi_ff, mode_lo_ff, multiproc_ff, rx_en_ff;
    reg tx_ninth_ff, rx_ninth_ff, recv_done_ff, xmit_done_ff;
    reg fe_sel_ff, doubler_ff, frame_err_ff;
    reg [7:0] addr_value_ff, addr_mask_ff, rx_buf_ff;
    reg [15:0] reload_ff;
    // receive path
    reg rxd_s1_ff, rxd_s2_ff, rxd_prev_ff;
    reg [1:0] rx_state_ff;
    reg [3:0] rx_slice_ff, rx_count_ff;
    reg [8:0] rx_shift_ff;
    reg [2:0] vote_ff;
    // transmit path
    reg [1:0] tx_state_ff;
    reg [3:0] tx_slice_ff, tx_count_ff;
    reg [10:0] tx_shift_ff;

    wire tick;
    wire hit;
    wire [1:0] mode;
    wire setup_wr, access;
    wire [9:0] idx;
    wire mapped;
    wire wr_ctl, wr_buf, wr_pwr;
    wire rx_bit;
    wire [3:0] rx_len, tx_len;
    wire rx_sample_done, stop_now;
    wire stop_level, ninth_val;
    wire accept;
    wire [7:0] rx_data;
    reg [31:0] nxt_rdata;

    // best of three samples; one noisy slice cannot flip a bit
    function maj3;
        input [2:0] v;
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    // frame length in bits, start and stop included
    function [3:0] frame_len;
        input [1:0] m;
        begin
            frame_len = (m == `MODE_ASYNC10) ? `BITS_ASYNC10 : `BITS_ASYNC11;
        end
    endfunction

    assign mode = {mode_hi_ff, mode_lo_ff};
    assign rx_len = frame_len(mode);
    assign tx_len = frame_len(mode);

    // shared slice tick; both directions run from one oversample rate
    // a rate change lands mid frame, so software sets it while idle
    baud_tick u_baud (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mode(mode),
        .doubler(doubler_ff),
        .reload(reload_ff),
        .tick_ff(tick)
    );

    // compare runs on the assembled byte; the result is used at the stop
    addr_match u_match (
        .rx_byte(rx_data),
        .addr_value(addr_value_ff),
        .addr_mask(addr_mask_ff),
        .hit(hit)
    );

    // apb decode: zero-wait slave, unmapped reads zero with error
    // every register is a full word; only the low bits carry state
    assign pready = 1'b1;
    assign access = psel & penable;
    assign idx = paddr[11:2];
    assign mapped = (idx == {2'b00, `IDX_SERIAL_CONTROL}) ||
                    (idx == {2'b00, `IDX_SERIAL_BUFFER}) ||
                    (idx == {2'b00, `IDX_POWER_CONTROL}) ||
                    (idx == {2'b00, `IDX_SLAVE_ADDR_VALUE}) ||
                    (idx == {2'b00, `IDX_SLAVE_ADDR_MASK}) ||
                    (idx == {2'b00, `IDX_BAUD_RELOAD});
    assign pslverr = access & ~mapped;
    assign setup_wr = access & pwrite;
    assign wr_ctl = setup_wr && idx == {2'b00, `IDX_SERIAL_CONTROL};
    assign wr_buf = setup_wr && idx == {2'b00, `IDX_SERIAL_BUFFER};
    assign wr_pwr = setup_wr && idx == {2'b00, `IDX_POWER_CONTROL};

    // read mux; bit seven shows error or mode bit per selector
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (idx == {2'b00, `IDX_SERIAL_CONTROL})
            nxt_rdata[7:0] = {fe_sel_ff ? frame_err_ff : mode_hi_ff,
                mode_lo_ff, multiproc_ff, rx_en_ff, tx_ninth_ff,
                rx_ninth_ff, xmit_done_ff, recv_done_ff};
        else if (idx == {2'b00, `IDX_SERIAL_BUFFER})
            nxt_rdata[7:0] = rx_buf_ff;
        else if (idx == {2'b00, `IDX_POWER_CONTROL})
            nxt_rdata[7:0] = {doubler_ff, fe_sel_ff, 6'h00};
        else if (idx == {2'b00, `IDX_SLAVE_ADDR_VALUE})
            nxt_rdata[7:0] = addr_value_ff;
        else if (idx == {2'b00, `IDX_SLAVE_ADDR_MASK})
            nxt_rdata[7:0] = addr_mask_ff;
        else if (idx == {2'b00, `IDX_BAUD_RELOAD})
            nxt_rdata[15:0] = reload_ff;
    end

    // read data captured in the setup phase so it stands from a flop
    // through the access phase; it shows state one cycle old
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= nxt_rdata;
    end

    // receive line synchroniser, then edge history from synced copy
    // reset to the idle level so no false start follows reset
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_prev_ff <= 1'b1;
        end else begin
            rxd_s1_ff <= rxd;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_prev_ff <= rxd_s2_ff;
        end
    end

    // decisions taken on the tick after the third sample
    assign rx_bit = maj3(vote_ff);
    assign rx_sample_done = tick && rx_slice_ff == `SAMPLE_C + 4'h1;
    assign stop_now = rx_sample_done && rx_count_ff == rx_len - 4'h1;
    assign stop_level = rx_bit;
    // mode 1: the stop bit is the ninth; else the shifted ninth
    assign ninth_val = (mode == `MODE_ASYNC10) ? stop_level : rx_shift_ff[8];
    // mode 1 shifts only eight bits, so its byte sits one place higher
    assign rx_data = (mode == `MODE_ASYNC10) ? rx_shift_ff[8:1] :
        rx_shift_ff[7:0];
    // filter: flag clear and (no multiproc, or ninth set and address hit)
    assign accept = ~recv_done_ff &&
        (~multiproc_ff || (ninth_val && hit));

    // receiver: falling-edge hunt, sixteen slices per bit
    // the slice count restarts at the edge so samples sit mid bit;
    // a start bit that reads high is dropped as a glitch
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_state_ff <= RX_IDLE;
            rx_slice_ff <= 4'h0;
            rx_count_ff <= 4'h0;
            rx_shift_ff <= 9'h000;
            vote_ff <= 3'b111;
        end else begin
            case (rx_state_ff)
                RX_IDLE: begin
                    // sync mode is not served here
                    if (rx_en_ff && mode != `MODE_SYNC &&
                            rxd_prev_ff && !rxd_s2_ff) begin
                        rx_state_ff <= RX_BITS;
                        rx_slice_ff <= 4'h0;
                        rx_count_ff <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (tick) begin
                        rx_slice_ff <= rx_slice_ff + 4'h1;
                        if (rx_slice_ff == `SAMPLE_A)
                            vote_ff[0] <= rxd_s2_ff;
                        if (rx_slice_ff == `SAMPLE_B)
                            vote_ff[1] <= rxd_s2_ff;
                        if (rx_slice_ff == `SAMPLE_C)
                            vote_ff[2] <= rxd_s2_ff;
                    end
                    if (rx_sample_done) begin
                        if (rx_count_ff == 4'h0 && rx_bit)
                            rx_state_ff <= RX_IDLE; // false start, abort
                        else if (stop_now)
                            rx_state_ff <= RX_IDLE;
                        else begin
                            rx_count_ff <= rx_count_ff + 4'h1;
                            if (rx_count_ff != 4'h0)
                                rx_shift_ff <= {rx_bit, rx_shift_ff[8:1]};
                        end
                    end
                end
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    // transmitter: waits for a slice rollover, then one bit per 16 slices
    // the slice count runs free: a write waits up to one bit time
    // before the start bit goes out, traded for a transmit slice counter that never restarts
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_state_ff <= TX_IDLE;
            tx_slice_ff <= 4'h0;
            tx_count_ff <= 4'h0;
            tx_shift_ff <= 11'h7FF;
            txd_ff <= 1'b1;
        end else begin
            if (tick)
                tx_slice_ff <= tx_slice_ff + 4'h1;
            case (tx_state_ff)
                TX_IDLE: begin
                    if (wr_buf && mode != `MODE_SYNC) begin
                        // stop, ninth, data, start
                        if (mode == `MODE_ASYNC10)
                            tx_shift_ff <= {2'b11, pwdata[7:0], 1'b0};
                        else
                            tx_shift_ff <= {1'b1, tx_ninth_ff,
                                pwdata[7:0], 1'b0};
                        tx_state_ff <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (tick && tx_slice_ff == `LAST_SLICE) begin
                        txd_ff <= tx_shift_ff[0];
                        tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                        tx_count_ff <= 4'h1;
                        tx_state_ff <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tick && tx_slice_ff == `LAST_SLICE) begin
                        if (tx_count_ff == tx_len) begin
                            tx_state_ff <= TX_IDLE; // done at last rollover
                            txd_ff <= 1'b1;
                        end else begin
                            txd_ff <= tx_shift_ff[0];
                            tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                            tx_count_ff <= tx_count_ff + 4'h1;
                        end
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    // control, flags and software registers; hardware set wins over clear
    // one process holds writes and hardware sets, so a set in the cycle
    // of a clear is ordered last and is never lost
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            {mode_hi_ff, mode_lo_ff, multiproc_ff, rx_en_ff} <= 4'h0;
            {tx_ninth_ff, rx_ninth_ff, recv_done_ff, xmit_done_ff} <= 4'h0;
            fe_sel_ff <= 1'b0;
            doubler_ff <= 1'b0;
            frame_err_ff <= 1'b0;
            addr_value_ff <= `RST_BYTE;
            addr_mask_ff <= `RST_BYTE;
            rx_buf_ff <= `RST_BYTE;
            reload_ff <= `RST_RELOAD;
        end else begin
            if (wr_ctl) begin
                // bit seven goes to the error flag or the mode bit
                if (fe_sel_ff)
                    frame_err_ff <= pwdata[`CTL_MODE_HI];
                else
                    mode_hi_ff <= pwdata[`CTL_MODE_HI];
                mode_lo_ff <= pwdata[`CTL_MODE_LO];
                multiproc_ff <= pwdata[`CTL_MULTIPROC];
                rx_en_ff <= pwdata[`CTL_RX_ENABLE];
                tx_ninth_ff <= pwdata[`CTL_TX_NINTH];
                rx_ninth_ff <= pwdata[`CTL_RX_NINTH];
                recv_done_ff <= pwdata[`CTL_RECV_DONE];
                xmit_done_ff <= pwdata[`CTL_XMIT_DONE];
            end
            if (wr_pwr) begin
                fe_sel_ff <= pwdata[`PWR_FE_SELECT];
                doubler_ff <= pwdata[`PWR_BAUD_DOUBLER];
            end
            if (setup_wr && idx == {2'b00, `IDX_SLAVE_ADDR_VALUE})
                addr_value_ff <= pwdata[7:0];
            if (setup_wr && idx == {2'b00, `IDX_SLAVE_ADDR_MASK})
                addr_mask_ff <= pwdata[7:0];
            if (setup_wr && idx == {2'b00, `IDX_BAUD_RELOAD})
                reload_ff <= pwdata[15:0];
            // stop check in every async frame, accepted or not
            if (rx_state_ff == RX_BITS && stop_now && !stop_level)
                frame_err_ff <= 1'b1;
            if (rx_state_ff == RX_BITS && stop_now && accept) begin
                rx_buf_ff <= rx_data;
                rx_ninth_ff <= ninth_val;
                recv_done_ff <= 1'b1;
            end
            // flag rises at the rollover that puts the stop bit out
            if (tx_state_ff == TX_SHIFT && tick &&
                    tx_slice_ff == `LAST_SLICE &&
                    tx_count_ff == tx_len - 4'h1)
                xmit_done_ff <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/serial_port_sva.sv */
// assertions on the serial port's bus and line behaviour
`timescale 1ns/1ps
`default_nettype none
module serial_port_sva (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd_ff
);
    logic [7:0] val_ff, msk_ff;
    logic sel_ff, hi_ff, lo_ff, fe_ff, rd_ff, txw_ff;
    wire acc = psel && penable && pready;
    wire wr_ctl = acc && pwrite && paddr == 12'h260;
    wire rd_ctl = acc && !pwrite && paddr == 12'h260;
    // shadows of software-owned state; flags remembered only once seen,
    // so a hardware set racing a clear can never cause a false alarm
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            {val_ff, msk_ff} <= 16'h0000;
            {sel_ff, hi_ff, lo_ff, fe_ff, rd_ff, txw_ff} <= 6'h00;
        end else begin
            if (acc && pwrite && paddr == 12'h2A4) val_ff <= pwdata[7:0];
            if (acc && pwrite && paddr == 12'h2E4) msk_ff <= pwdata[7:0];
            if (acc && pwrite && paddr == 12'h21C) sel_ff <= pwdata[6];
            if (acc && pwrite && paddr == 12'h264) txw_ff <= 1'b1;
            if (wr_ctl) lo_ff <= pwdata[6];
            if (wr_ctl && !sel_ff) hi_ff <= pwdata[7];
            if (wr_ctl && sel_ff && !pwdata[7]) fe_ff <= 1'b0;
            else if (rd_ctl && sel_ff && prdata[7]) fe_ff <= 1'b1;
            if (wr_ctl && !pwdata[0]) rd_ff <= 1'b0;
            else if (rd_ctl && prdata[0]) rd_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    map_ok_a:
        assert property (acc && (paddr == 12'h2A4 || paddr == 12'h2E4)
            |-> !pslverr) else $error("address register refused");
    addr_value_a:
        assert property (acc && !pwrite && paddr == 12'h2A4
            |-> prdata[7:0] == val_ff) else $error("address value wrong");
    addr_mask_a:
        assert property (acc && !pwrite && paddr == 12'h2E4
            |-> prdata[7:0] == msk_ff) else $error("address mask wrong");
    mode_bits_a:
        assert property (rd_ctl && !sel_ff |-> prdata[7:6] == {hi_ff, lo_ff})
            else $error("mode bits read back wrong");
    fe_sticky_a:
        assert property (rd_ctl && sel_ff && fe_ff |-> prdata[7])
            else $error("frame error flag lost");
    done_sticky_a:
        assert property (rd_ctl && rd_ff |-> prdata[0])
            else $error("receive flag lost");
    line_idle_a:
        assert property (!txw_ff |-> txd_ff)
            else $error("line left idle without a buffer write");
    start_len_a:
        assert property ($fell(txd_ff) |=> !txd_ff [*8])
            else $error("start bit too short");
endmodule
bind serial_port serial_port_sva i_sva (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd_ff(txd_ff));
`default_nettype wire

/* tb/serial_node.sv */
// far serial node: drives frames onto the receive line, captures transmit
`timescale 1ns/1ps
`default_nettype none
module serial_node (
    input wire logic clk_sys,
    input wire logic txd_ff,
    output var logic rxd
);
    // line rests at the stop level between frames
    initial rxd = 1'b1;
    // bits[0] is the start bit; data follow lsb first
    task automatic send(input logic [10:0] bits, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rxd <= bits[i];
            repeat (bc - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        rxd <= 1'b1;
    endtask
    // sample mid bit; a missing start leaves ones, which fail the compare
    task automatic grab(input int n, input int bc, output logic [10:0] bits);
        int w;
        w = 0;
        bits = 11'h7FF;
        while (txd_ff !== 1'b0 && w < 4000) begin
            @(posedge clk_sys);
            w++;
        end
        repeat (bc / 2) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            bits[i] = txd_ff;
            repeat (bc) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench: registers, reception, address filter, transmission
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [11:0] a_ctl = 12'h260, a_buf = 12'h264;
    localparam logic [11:0] a_pwr = 12'h21C, a_rld = 12'h300;
    localparam logic [11:0] a_val = 12'h2A4, a_msk = 12'h2E4;
    logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, err_seen;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [10:0] bits;
    wire [31:0] prdata;
    wire pready, pslverr, txd_ff, rxd;
    int mismatches = 0, checks_done = 0;
    serial_port i_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd_ff(txd_ff));
    serial_node i_node (.clk_sys(clk_sys), .txd_ff(txd_ff), .rxd(rxd));
    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;
    task summarize;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; the answer is awaited under a bound, never assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err_seen = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 64) begin
            mismatches++;
            summarize;
        end
    endtask
    // fastest baud keeps frames short; selector low
    task setup(input logic [1:0] m, input logic mp, input logic t9);
        apb(1'b1, a_pwr, 32'h80);
        apb(1'b1, a_rld, 32'h0);
        apb(1'b1, a_ctl, {24'h0, m, mp, 1'b1, t9, 3'b000});
    endtask
    task rx(input logic [1:0] m, input logic [7:0] d, input logic b9,
        input logic s);
        i_node.send({s, b9, d, 1'b0}, m == 2'b01 ? 10 : 11,
            m == 2'b10 ? 32 : 16);
        repeat (4) @(posedge clk_sys);
    endtask
    task t_regs;
        apb(1'b0, a_val, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, a_msk, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, a_val, 32'hA4);
        apb(1'b1, a_msk, 32'hFA);
        apb(1'b0, a_val, 32'h0);
        chk(rd, 32'hA4);
        apb(1'b0, a_msk, 32'h0);
        chk(rd, 32'hFA);
        apb(1'b1, a_rld, 32'h1234);
        apb(1'b0, a_rld, 32'h0);
        chk(rd, 32'h1234);
        apb(1'b0, 12'h004, 32'h0);
        chk({rd[30:0], err_seen}, 32'h1);
        $display("registers done");
    endtask
    task t_modes;
        apb(1'b1, a_pwr, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, a_ctl, {24'h0, i[1:0], 6'h00});
            apb(1'b0, a_ctl, 32'h0);
            chk({30'h0, rd[7:6]}, {30'h0, i[1:0]});
        end
        apb(1'b1, a_pwr, 32'h40);
        apb(1'b0, a_pwr, 32'h0);
        chk(rd, 32'h40);
        apb(1'b0, a_ctl, 32'h0);
        chk({31'h0, rd[7]}, 32'h0);
        apb(1'b1, a_pwr, 32'h0);
        apb(1'b0, a_ctl, 32'h0);
        chk({31'h0, rd[7]}, 32'h1);
        $display("modes done");
    endtask
    // second frame dropped while the flag is up; bad stop still flagged
    task t_rx;
        logic [1:0] m;
        for (int i = 1; i < 4; i++) begin
            m = i[1:0];
            setup(m, 1'b0, 1'b0);
            rx(m, 8'hA5, 1'b1, 1'b1);
            rx(m, 8'h11, 1'b1, 1'b1);
            apb(1'b0, a_buf, 32'h0);
            chk(rd, 32'hA5);
            rx(m, 8'h3C, m != 2'b01, 1'b0);
            apb(1'b1, a_pwr, 32'hC0);
            apb(1'b0, a_ctl, 32'h0);
            chk({28'h0, rd[7], rd[2:0]}, 32'hD);
            apb(1'b1, a_ctl, {24'h0, 1'b1, m[0], 6'h10});
            rx(m, 8'h5A, 1'b1, 1'b1);
            apb(1'b0, a_ctl, 32'h0);
            chk({28'h0, rd[7], rd[2:0]}, 32'hD);
            apb(1'b1, a_ctl, {24'h0, 1'b0, m[0], 6'h10});
            apb(1'b0, a_ctl, 32'h0);
            chk({31'h0, rd[7]}, 32'h0);
        end
        $display("receive done");
    endtask
    // table: mode, expected flag, ninth bit, byte; value A4, mask FA
    task t_filter;
        logic [11:0] tbl [9] = '{12'hFA0, 12'hFA1, 12'hDA2, 12'hFFF,
            12'hFFE, 12'hCA0, 12'h97E, 12'h7A5, 12'h5A2};
        foreach (tbl[i]) begin
            setup(tbl[i][11:10], 1'b1, 1'b0);
            rx(tbl[i][11:10], tbl[i][7:0], tbl[i][8], 1'b1);
            apb(1'b0, a_ctl, 32'h0);
            chk(rd[0], tbl[i][9]);
        end
        setup(2'b11, 1'b1, 1'b0);
        i_node.send({2'b11, 8'hA2, 1'b0}, 11, 16);
        rx(2'b11, 8'hFF, 1'b1, 1'b1);
        apb(1'b0, a_buf, 32'h0);
        chk(rd, 32'hFF);
        $display("filter done");
    endtask
    task t_tx;
        logic [1:0] m;
        logic t9;
        logic [31:0] e;
        for (int i = 1; i < 4; i++) begin
            m = i[1:0];
            t9 = m != 2'b11;
            e = {22'h1, t9, 8'hC3 ^ {6'h0, m}, 1'b0};
            setup(m, 1'b0, t9);
            apb(1'b1, a_buf, {24'h0, 8'hC3 ^ {6'h0, m}});
            i_node.grab(m == 2'b01 ? 10 : 11, m == 2'b10 ? 32 : 16, bits);
            chk({21'h0, bits}, e);
            apb(1'b0, a_ctl, 32'h0);
            chk({31'h0, rd[1]}, 32'h1);
        end
        $display("transmit done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs;
        t_modes;
        t_rx;
        t_filter;
        t_tx;
        summarize;
    end
endmodule
`default_nettype wire
